// ===== dpc_pkg.sv
// Package for the dual-port RAM host controller: pin carriers, timing counts and commands.
// Assumes a single 20 MHz system clock; the RAM itself is clockless and sits outside.
package dpc_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS          = 50;
    localparam int ACCESS_TIME_NS         = 20;
    localparam int FLOWTHROUGH_DELAY_NS   = 20;
    localparam int BUSY_FROM_MATCH_DELAY_NS  = 20;
    localparam int BUSY_FROM_SELECT_DELAY_NS = 20;
    localparam int TOKEN_UPDATE_PULSE_NS  = 10;
    localparam int WRITE_PULSE_NS         = 20;
    localparam int ACCESS_CYC   = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOW_CYC     = (FLOWTHROUGH_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_SETTLE_CYC =
        (((BUSY_FROM_MATCH_DELAY_NS > BUSY_FROM_SELECT_DELAY_NS) ? BUSY_FROM_MATCH_DELAY_NS
          : BUSY_FROM_SELECT_DELAY_NS) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UPDATE_CYC   = (TOKEN_UPDATE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC    = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // Geometry and mailboxes
    // ****************************************************************
    localparam int ADDR_W = 17;
    localparam int DATA_W = 9;
    localparam logic [16:0] MBOX_RIGHT_64K  = 17'h0ffff;
    localparam logic [16:0] MBOX_LEFT_64K   = 17'h0fffe;
    localparam logic [16:0] MBOX_RIGHT_128K = 17'h1ffff;
    localparam logic [16:0] MBOX_LEFT_128K  = 17'h1fffe;
    localparam int TOKEN_COUNT = 8;
    localparam int TOKEN_SEL_W = 3;

    // ****************************************************************
    // Commands and pin carriers
    // ****************************************************************
    typedef enum logic [1:0] {
        DPC_CMD_READ     = 2'b00,
        DPC_CMD_WRITE    = 2'b01,
        DPC_CMD_TOK_READ = 2'b10,
        DPC_CMD_TOK_WRITE= 2'b11
    } dpc_cmd_t;

    typedef struct packed {
        dpc_cmd_t            cmd;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } dpc_req_t;

    typedef struct packed {
        logic chip_select_n;
        logic token_latch_select_n;
        logic output_enable_n;
        logic read_write_n;
    } dpc_strobe_t;

endpackage : dpc_pkg

// ===== dpc_host.sv
// Host-side controller for one port of an asynchronous dual-port RAM with mailbox and tokens.
// Assumes the RAM's port pins are wired straight to this module and sampled on sys_clk.
// Summary of operation
// [RQ1] Memory read drives output enable and chip select together, then waits access time.
// [RQ2] Token read drives token select instead of chip select, plus output enable.
// [RQ3] A read after the far port writes waits the flowthrough delay first.
// [RQ4] Highest address is the right port's mailbox.
// [RQ5] Second-highest address is the left port's mailbox.
// [RQ6] Writing the far mailbox raises the owner's interrupt.
// [RQ7] Reading one's own mailbox clears one's interrupt.
// [RQ8] Reading the far mailbox clears nothing.
// [RQ9] A busy port's write to the far mailbox sets no interrupt.
// [RQ10] A busy port's read of its own mailbox clears nothing.
// [RQ11] Matching addresses are arbitrated; the loser sees busy.
// [RQ12] Strap high makes busy an output, strap low an input.
// [RQ13] Writes wait until the busy input has settled; token writes here skip ST_SETTLE and go straight to ST_ACCESS.
// [RQ14] Port deselects and floats data when neither select is active.
// [RQ15] Eight token latches; request by writing zero, confirm by reading back.
// [RQ16] Selects stay inactive for the update pulse between token write and read.
// [RQ17] Token access keeps chip select inactive; low three address bits choose the latch.
// [RQ18] Token write uses only data bit 0.
// [RQ19] A granted token reads zero to owner and one to the other port.
// [RQ20] Owner writing one with nothing pending frees the token.
// [RQ21] A pending request takes the token when the owner releases it.
// [RQ22] Token reads drive the value on all data lines, latched.
// [RQ23] Simultaneous token requests grant exactly one side.
// [RQ24] Chip select and token select are never active together.
// [RQ25] Interrupt and busy pins are active low.
`timescale 1ns/10ps
module dpc_host
    import dpc_pkg::*;
#(
    parameter int ACC_CYCLES    = ACCESS_CYC,
    parameter int FLOW_CYCLES   = FLOW_CYC,
    parameter int SETTLE_CYCLES = BUSY_SETTLE_CYC,
    parameter int UPDATE_CYCLES = UPDATE_CYC,
    parameter int WR_CYCLES     = WRITE_CYC
) (
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire dpc_req_t          req,
    input  wire logic              far_write_seen,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    output logic                   rsp_busy,
    output logic                   mailbox_irq,
    output logic [ADDR_W-1:0]      ram_addr,
    output logic [DATA_W-1:0]      ram_data_out,
    output logic                   ram_data_oe,
    input  wire logic [DATA_W-1:0] ram_data_in,
    output dpc_strobe_t            ram_strobe,
    input  wire logic              ram_busy_n,
    input  wire logic              ram_irq_n
);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_FLOW   = 3'b001,
        ST_SETTLE = 3'b010,
        ST_ACCESS = 3'b011,
        ST_GAP    = 3'b100
    } dpc_state_t;

    dpc_state_t        state_q;
    dpc_req_t          cur_q;
    logic [7:0]        cnt_q;
    logic              flow_pend_q;
    logic              tok_recent_q;
    logic              drive_now;
    logic              last_now;

    function automatic logic is_token(input dpc_cmd_t c);
        return c[1];
    endfunction : is_token

    function automatic logic is_write(input dpc_cmd_t c);
        return c[0];
    endfunction : is_write

    // Strobes are registered, so they go active one edge after the state enters the access phase.
    // The extra count keeps them asserted for the full access length, even at one cycle.
    function automatic logic [7:0] access_len(input dpc_cmd_t c);
        return 8'((is_write(c) ? WR_CYCLES : ACC_CYCLES) + 1);
    endfunction : access_len

    assign req_ready   = (state_q == ST_IDLE);
    assign drive_now   = (state_q == ST_ACCESS) && (cnt_q > 8'h01);
    assign last_now    = (state_q == ST_ACCESS) && (cnt_q <= 8'h01);
    assign mailbox_irq = ~ram_irq_n;                                      // [RQ25]

    // Far-side writes arm a flowthrough wait so the next read is deterministic.
    // Only a finished read consumes the wait; an own write in between must not discard it.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flow_pend_q <= 1'b0;
        end else if (far_write_seen) begin
            flow_pend_q <= 1'b1;                                          // [RQ3]
        end else if (last_now && !is_write(cur_q.cmd)) begin
            flow_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q      <= ST_IDLE;
            cur_q        <= '0;
            cnt_q        <= 8'h00;
            tok_recent_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (req_valid) begin
                        cur_q <= req;
                        if (!is_write(req.cmd) && flow_pend_q) begin
                            state_q <= ST_FLOW;                           // [RQ3]
                            cnt_q   <= 8'(FLOW_CYCLES);
                        end else if (is_token(req.cmd) && !is_write(req.cmd) && tok_recent_q) begin
                            state_q <= ST_GAP;                            // [RQ16]
                            cnt_q   <= 8'(UPDATE_CYCLES);
                        end else if (is_write(req.cmd) && !is_token(req.cmd)) begin
                            state_q <= ST_SETTLE;                         // [RQ13]
                            cnt_q   <= 8'(SETTLE_CYCLES);
                        end else begin
                            state_q <= ST_ACCESS;
                            cnt_q   <= access_len(req.cmd);
                        end
                    end
                end
                ST_FLOW, ST_GAP, ST_SETTLE: begin
                    if (cnt_q <= 8'h01) begin
                        state_q <= ST_ACCESS;
                        cnt_q   <= access_len(cur_q.cmd);
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ST_ACCESS: begin
                    if (cnt_q <= 8'h01) begin
                        state_q      <= ST_IDLE;
                        // Only a token read right after a token write needs the update gap.
                        tok_recent_q <= is_token(cur_q.cmd) && is_write(cur_q.cmd);
                        cnt_q        <= 8'h00;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    // Both selects are inactive outside an access so the port powers down and floats.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ram_strobe <= '{1'b1, 1'b1, 1'b1, 1'b1};                      // [RQ14]
        end else if (drive_now) begin
            // Token access keeps chip select high; memory access keeps token select high.
            ram_strobe.chip_select_n        <= is_token(cur_q.cmd);       // [RQ1] [RQ24]
            ram_strobe.token_latch_select_n <= ~is_token(cur_q.cmd);      // [RQ2] [RQ17]
            ram_strobe.output_enable_n      <= is_write(cur_q.cmd);       // [RQ1] [RQ2]
            ram_strobe.read_write_n         <= ~is_write(cur_q.cmd);
        end else begin
            ram_strobe <= '{1'b1, 1'b1, 1'b1, 1'b1};                      // [RQ14] [RQ16]
        end
    end

    // The address is held after an access; with both selects high the port ignores it.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ram_addr <= '0;
        end else if (drive_now) begin
            ram_addr <= is_token(cur_q.cmd)
                      ? {{(ADDR_W-TOKEN_SEL_W){1'b0}}, cur_q.addr[TOKEN_SEL_W-1:0]}
                      : cur_q.addr;                                       // [RQ17]
        end
    end

    // The data drivers are released as soon as the write strobe ends.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ram_data_out <= '0;
            ram_data_oe  <= 1'b0;
        end else if (drive_now) begin
            ram_data_out <= is_token(cur_q.cmd)
                          ? {{(DATA_W-1){1'b0}}, cur_q.wdata[0]}          // [RQ18] [RQ15]
                          : cur_q.wdata;
            ram_data_oe  <= is_write(cur_q.cmd);
        end else begin
            ram_data_oe  <= 1'b0;
        end
    end

    // ****************************************************************
    // Answer capture
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= last_now;
        end
    end

    // Data and busy are sampled in the last driven cycle, after the access delay has passed.
    // A busy answer means the far port won the location; the caller must retry the access.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_data <= '0;
            rsp_busy <= 1'b0;
        end else if (last_now) begin
            rsp_data <= is_write(cur_q.cmd) ? '0 : ram_data_in;          // [RQ22] [RQ19]
            rsp_busy <= ~ram_busy_n;                                      // [RQ11] [RQ25]
        end
    end

endmodule : dpc_host

// ===== dpc_host_assertions.sv
// Port checker for the dual-port RAM host controller.
// Assumes it is bound to dpc_host and sees only its ports.
`timescale 1ns/10ps
module dpc_host_assertions
    import dpc_pkg::*;
#(
    parameter int ACC_CYCLES  = ACCESS_CYC,
    parameter int FLOW_CYCLES = FLOW_CYC
) (
    input wire logic              sys_clk,
    input wire logic              reset_n,
    input wire logic              req_valid,
    input wire logic              req_ready,
    input wire dpc_req_t          req,
    input wire logic              rsp_valid,
    input wire logic              rsp_busy,
    input wire logic              mailbox_irq,
    input wire logic              ram_data_oe,
    input wire dpc_strobe_t       ram_strobe,
    input wire logic [ADDR_W-1:0] ram_addr,
    input wire logic              ram_busy_n,
    input wire logic              ram_irq_n
);
    // ***
    // Properties
    // ***
    localparam int RD_MIN = ACC_CYCLES + 2;
    localparam int RD_MAX = ACC_CYCLES + FLOW_CYCLES + 2;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire cs   = !ram_strobe.chip_select_n;
    wire ts   = !ram_strobe.token_latch_select_n;
    wire rd   = !ram_strobe.output_enable_n;
    wire wr   = !ram_strobe.read_write_n;
    wire take = req_valid && req_ready;
    property p_sel_excl; !(cs && ts); endproperty
    property p_rd_sel; rd |-> (cs != ts) && !wr; endproperty
    property p_tok_addr; ts && $past(ts) |-> $stable(ram_addr[2:0]); endproperty
    property p_wr_settle; take && req.cmd == DPC_CMD_WRITE |=> !wr [*2]; endproperty
    property p_wr_drive; wr |-> ram_data_oe; endproperty
    property p_irq; mailbox_irq == !ram_irq_n; endproperty
    property p_rd_lat; take && req.cmd == DPC_CMD_READ |-> ##[RD_MIN:RD_MAX] rsp_valid; endproperty
    property p_tok_gap; $fell(ts) && $past(wr) |=> !ts; endproperty
    property p_busy_rsp; rsp_valid |-> rsp_busy == !$past(ram_busy_n); endproperty
    a_sel_excl: assert property (p_sel_excl) else $error("both selects");
    a_rd_sel: assert property (p_rd_sel) else $error("bad read select");
    a_tok_addr: assert property (p_tok_addr) else $error("token addr moved");
    a_wr_settle: assert property (p_wr_settle) else $error("write too early");
    a_wr_drive: assert property (p_wr_drive) else $error("write undriven");
    a_irq: assert property (p_irq) else $error("irq polarity");
    a_rd_lat: assert property (p_rd_lat) else $error("read latency");
    a_tok_gap: assert property (p_tok_gap) else $error("token gap");
    a_busy_rsp: assert property (p_busy_rsp) else $error("busy report");
    c_rd: cover property (take && req.cmd == DPC_CMD_READ);
    c_tok: cover property (ts && rd);
    c_busy: cover property (rsp_valid && rsp_busy);
endmodule : dpc_host_assertions
bind dpc_host dpc_host_assertions #(.ACC_CYCLES(ACC_CYCLES), .FLOW_CYCLES(FLOW_CYCLES)) u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp_busy(rsp_busy), .mailbox_irq(mailbox_irq),
    .ram_data_oe(ram_data_oe), .ram_strobe(ram_strobe), .ram_addr(ram_addr),
    .ram_busy_n(ram_busy_n), .ram_irq_n(ram_irq_n));

// ===== dpc_ram_model.sv
// Model of the left port of the dual-port RAM with mailbox and token latches.
// Assumes registered strobes; the far port is imitated by three bench inputs.
`timescale 1ns/10ps
module dpc_ram_model
    import dpc_pkg::*;
(
    input  wire logic [ADDR_W-1:0] ram_addr,
    input  wire logic [DATA_W-1:0] ram_data_out,
    input  wire dpc_strobe_t       ram_strobe,
    output logic [DATA_W-1:0]      ram_data_in,
    output logic                   ram_busy_n,
    output logic                   ram_irq_n,
    input  wire logic              far_mail,
    input  wire logic              contend,
    input  wire logic [7:0]        far_hold
);
    // ***
    // Port behaviour
    // ***
    logic [DATA_W-1:0] mem [int];
    logic [7:0]        own  = 8'h00;
    logic [7:0]        pend = 8'h00;
    logic              irq  = 1'b0;
    logic              far_irq = 1'b0;
    logic              drv  = 1'b0;
    wire cs = !ram_strobe.chip_select_n;
    wire ts = !ram_strobe.token_latch_select_n;
    wire rd = !ram_strobe.output_enable_n;
    wire wr = !ram_strobe.read_write_n;
    assign ram_busy_n = !(contend && cs);
    assign ram_irq_n = !irq;
    initial ram_data_in = 9'h0aa;
    always @(posedge far_mail) irq = 1'b1;
    always @(far_hold) begin
        own = own | (pend & ~far_hold);
        pend = pend & far_hold;
    end
    // Address and data change in the time step of the strobes; the short wait lets them settle.
    always @(ram_strobe) begin
        #1;
        if (rd && cs) begin
            ram_data_in = mem[ram_addr];
            drv = 1'b1;
        end else if (rd && ts) begin
            ram_data_in = {DATA_W{!own[ram_addr[2:0]]}};
            drv = 1'b1;
        end else if (drv) begin
            ram_data_in = ~ram_data_in;
            drv = 1'b0;
        end
        if (rd && cs && ram_addr == MBOX_LEFT_128K && !contend) irq = 1'b0;
        if (wr && cs && ram_addr == MBOX_RIGHT_128K && !contend) far_irq = 1'b1;
        if (wr && cs) mem[ram_addr] = ram_data_out;
        if (wr && ts) begin
            if (ram_data_out[0]) begin
                own[ram_addr[2:0]] = 1'b0;
                pend[ram_addr[2:0]] = 1'b0;
            end else if (far_hold[ram_addr[2:0]]) pend[ram_addr[2:0]] = 1'b1;
            else own[ram_addr[2:0]] = 1'b1;
        end
    end
endmodule : dpc_ram_model

// ===== dual_port_ram_arbitration_mailbox_tb.sv
// Self-checking bench: host controller against the RAM port model.
// Assumes the package, design, checker and model are compiled first.
`timescale 1ns/10ps
module dual_port_ram_arbitration_mailbox_tb
    import dpc_pkg::*;
;
    logic sys_clk = 0, reset_n = 0, req_valid = 0, far_write_seen = 0, far_mail = 0, contend = 0;
    logic [7:0] far_hold = 8'h00, tok_exp = 8'h00;
    logic [16:0] seed = 17'h0000a, ram_addr;
    logic [8:0] rsp_data, ram_data_out, ram_data_in, got, mem_exp [int];
    logic req_ready, rsp_valid, rsp_busy, mailbox_irq, ram_data_oe, ram_busy_n, ram_irq_n, gotb;
    dpc_req_t req = '0;
    dpc_strobe_t ram_strobe;
    int n_errors = 0, checks = 0;
    initial forever #25 sys_clk = ~sys_clk;
    dpc_host #(.ACC_CYCLES(3), .FLOW_CYCLES(1), .SETTLE_CYCLES(1), .UPDATE_CYCLES(1),
        .WR_CYCLES(2)) dpc_host_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
        .far_write_seen(far_write_seen), .rsp_data(rsp_data), .rsp_busy(rsp_busy),
        .mailbox_irq(mailbox_irq), .ram_addr(ram_addr), .ram_data_out(ram_data_out),
        .ram_data_oe(ram_data_oe), .ram_data_in(ram_data_in), .ram_strobe(ram_strobe),
        .ram_busy_n(ram_busy_n), .ram_irq_n(ram_irq_n));
    dpc_ram_model dpc_ram_model_inst (.ram_addr(ram_addr), .ram_data_out(ram_data_out),
        .ram_strobe(ram_strobe), .ram_data_in(ram_data_in), .ram_busy_n(ram_busy_n),
        .ram_irq_n(ram_irq_n), .far_mail(far_mail), .contend(contend), .far_hold(far_hold));
    function automatic logic [16:0] lfsr(logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr
    task automatic check(string nm, logic [16:0] s, logic [16:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic op(dpc_cmd_t c, logic [16:0] a, logic [8:0] d);
        @(posedge sys_clk);
        #2;
        req = '{cmd: c, addr: a, wdata: d};
        req_valid = 1'b1;
        do @(posedge sys_clk); while (req_ready !== 1'b1);
        #2;
        req_valid = 1'b0;
        for (int i = 0; i < 30 && rsp_valid !== 1'b1; i++) begin
            @(posedge sys_clk);
            #2;
        end
        got = rsp_data;
        gotb = rsp_busy;
        check("response", rsp_valid, 1);
    endtask : op
    task automatic print_verdict;
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    // The sequence needs about a twenty-fifth of this span; a hang still ends the run.
    initial begin
        #400000;
        n_errors++;
        print_verdict;
    end
    initial begin
        logic [16:0] a;
        repeat (3) @(posedge sys_clk);
        #2 reset_n = 1'b1;
        check("idle", {ram_strobe, ram_data_oe, req_ready}, 6'h3d);
        op(DPC_CMD_WRITE, MBOX_LEFT_128K, 9'h155);
        contend = 1'b1;
        op(DPC_CMD_WRITE, MBOX_RIGHT_128K, 9'h0aa);
        check("far_irq_busy", {gotb, dpc_ram_model_inst.far_irq}, 2'b10);
        contend = 1'b0;
        op(DPC_CMD_WRITE, MBOX_RIGHT_128K, 9'h0aa);
        check("far_irq_set", dpc_ram_model_inst.far_irq, 1);
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            // Bit 16 is kept low so that no random write lands on a mailbox word.
            a = {1'b0, seed[15:0]};
            seed = lfsr(seed);
            mem_exp[a] = seed[8:0];
            op(DPC_CMD_WRITE, a, seed[8:0]);
            check("wr_data", got, 0);
            if (k[0]) begin
                far_write_seen = 1'b1;
                @(posedge sys_clk);
                #2 far_write_seen = 1'b0;
            end
            op(DPC_CMD_READ, a, 9'h000);
            check("rd_data", got, mem_exp[a]);
        end
        far_mail = 1'b1;
        #50 far_mail = 1'b0;
        check("irq_set", mailbox_irq, 1);
        op(DPC_CMD_READ, MBOX_RIGHT_128K, 9'h000);
        check("irq_far", {got, mailbox_irq}, {9'h0aa, 1'b1});
        contend = 1'b1;
        op(DPC_CMD_READ, MBOX_LEFT_128K, 9'h000);
        check("irq_busy", {gotb, mailbox_irq}, 2'b11);
        contend = 1'b0;
        op(DPC_CMD_READ, MBOX_LEFT_128K, 9'h000);
        check("irq_clr", {got, gotb, mailbox_irq}, {9'h155, 2'b00});
        for (int t = 0; t < 8; t++) begin
            seed = lfsr(seed);
            op(DPC_CMD_TOK_WRITE, {seed[16:3], 3'(t)}, {seed[8:1], 1'b0});
            tok_exp[t] = 1'b1;
            op(DPC_CMD_TOK_READ, {seed[13:0], 3'(t)}, 9'h000);
            check("tok_own", got, {9{!tok_exp[t]}});
            op(DPC_CMD_TOK_WRITE, 17'(t), 9'h1ff);
            tok_exp[t] = 1'b0;
            op(DPC_CMD_TOK_READ, 17'(t), 9'h000);
            check("tok_free", got, {9{!tok_exp[t]}});
        end
        far_hold = 8'h08;
        op(DPC_CMD_TOK_WRITE, 17'h00003, 9'h000);
        op(DPC_CMD_TOK_READ, 17'h00003, 9'h000);
        check("tok_wait", got, 9'h1ff);
        far_hold = 8'h00;
        op(DPC_CMD_TOK_READ, 17'h00003, 9'h000);
        check("tok_pass", got, 9'h000);
        print_verdict;
    end
endmodule : dual_port_ram_arbitration_mailbox_tb
